// ==== rtl/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;

  // ==========================================================
  // data and configuration layout
  localparam int          RES_W          = 16;
  localparam int          CHAN_MAX       = 8;
  localparam int          HALF_CHAN      = 4;
  localparam logic [15:0] CFG_RESET      = 16'hffff;
  localparam int          CFG_UPDATE_BIT = 15;
  localparam int          CFG_CHAN_HI    = 14;
  localparam int          CFG_CHAN_LO    = 13;
  localparam int          CFG_DUAL_BIT   = 0;
  localparam int          CFG_BITS       = 16;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS  = 1000;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // pin synchroniser bit positions and reset levels
  localparam int         SYNC_W   = 6;
  localparam int         SY_CNV   = 0;
  localparam int         SY_RST   = 1;
  localparam int         SY_PD    = 2;
  localparam int         SY_CS    = 3;
  localparam int         SY_SCK   = 4;
  localparam int         SY_DIN   = 5;
  localparam logic [5:0] SYNC_RST = 6'h08;

  // ==========================================================
  // conversion sequencer states, gray ring
  typedef enum logic [1:0] {
    CONV_IDLE    = 2'b00,
    CONV_SAMPLE  = 2'b01,
    CONV_COLLECT = 2'b11,
    CONV_DONE    = 2'b10
  } conv_state_t;

endpackage

// ==== rtl/result_store.sv ====
`timescale 1ns/100ps
`default_nettype none

module result_store #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [ADDR_W-1:0] rd_addr_a_i,
  input  wire logic [ADDR_W-1:0] rd_addr_b_i,
  output logic      [DATA_W-1:0] rd_data_a_o,
  output logic      [DATA_W-1:0] rd_data_b_o
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // ==========================================================
  // elaboration checks
  if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin : g_bad_param
    $error("result_store parameters out of range");
  end

  // ==========================================================
  // write port
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // ==========================================================
  // two registered read ports
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_a_o <= '0;
      rd_data_b_o <= '0;
    end else begin
      rd_data_a_o <= mem[rd_addr_a_i];
      rd_data_b_o <= mem[rd_addr_b_i];
    end
  end

endmodule
`default_nettype wire

// ==== rtl/simultaneous_adc_serial_control.sv ====
`timescale 1ns/100ps
`default_nettype none

module simultaneous_adc_serial_control
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              conversion_start_i,
  input  wire logic              device_reset_i,
  input  wire logic              power_down_input_i,
  input  wire logic              cs_n_i,
  input  wire logic              sck_i,
  input  wire logic              din_i,
  output logic                   conv_request_o,
  output logic      [3:0]        conv_count_o,
  input  wire logic              sample_valid_i,
  input  wire logic [RES_W-1:0]  sample_data_i,
  output logic                   sample_ready_o,
  output logic                   sdo_o,
  output logic                   sdo_oe_o,
  output logic                   busy_second_data_out_o,
  output logic      [RES_W-1:0]  config_word_o
);

  // ==========================================================
  // elaboration checks
  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
    $error("CONV_CYCLES out of range");
  end

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] sync_c;

  assign pin_raw = {din_i, sck_i, cs_n_i, power_down_input_i, device_reset_i,
                    conversion_start_i};

  // two flops per pin, third stage for edge detection and for the readout word index
  for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        sync_a[g] <= SYNC_RST[g];
        sync_b[g] <= SYNC_RST[g];
        sync_c[g] <= SYNC_RST[g];
      end else begin
        sync_a[g] <= pin_raw[g];
        sync_b[g] <= sync_a[g];
        sync_c[g] <= sync_b[g];
      end
    end
  end

  logic cnv_rise;
  logic halt;
  logic cs_s;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic din_s;

  // edges found from samples, so either idle level of the clock works
  assign cnv_rise = sync_b[SY_CNV] & ~sync_c[SY_CNV];
  assign halt     = sync_b[SY_RST] | sync_b[SY_PD];
  assign cs_s     = sync_b[SY_CS];
  assign cs_fall  = ~sync_b[SY_CS] & sync_c[SY_CS];
  assign sck_rise = sync_b[SY_SCK] & ~sync_c[SY_SCK];
  assign sck_fall = ~sync_b[SY_SCK] & sync_c[SY_SCK];
  assign din_s    = sync_b[SY_DIN];

  // ==========================================================
  // conversion sequencer
  conv_state_t state;
  logic [15:0] cyc_cnt;
  logic [3:0]  wr_ptr;
  logic [15:0] config_word;
  logic [15:0] conv_cfg;
  logic [3:0]  chan_cnt_cfg;
  logic [3:0]  chan_cnt;
  logic        eoc;
  logic        busy;

  // channel count from the selection field
  assign chan_cnt_cfg = {1'b0, config_word[CFG_CHAN_HI:CFG_CHAN_LO], 1'b0} + 4'h2;
  assign chan_cnt     = {1'b0, conv_cfg[CFG_CHAN_HI:CFG_CHAN_LO], 1'b0} + 4'h2;
  assign eoc          = (state == CONV_DONE);
  assign busy         = (state == CONV_SAMPLE) || (state == CONV_COLLECT);

  // state transitions; starts while busy fall through unseen
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || halt) begin
      state <= CONV_IDLE;
    end else begin
      unique case (state)
        CONV_IDLE: begin
          if (cnv_rise) begin
            state <= CONV_SAMPLE;
          end
        end
        CONV_SAMPLE: begin
          if (cyc_cnt == 16'(CONV_CYCLES - 1)) begin
            state <= CONV_COLLECT;
          end
        end
        CONV_COLLECT: begin
          if (wr_ptr == chan_cnt) begin
            state <= CONV_DONE;
          end
        end
        CONV_DONE: begin
          state <= CONV_IDLE;
        end
      endcase
    end
  end

  // quiet phase timer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state != CONV_SAMPLE) begin
      cyc_cnt <= '0;
    end else begin
      cyc_cnt <= cyc_cnt + 16'h0001;
    end
  end

  // settings frozen at start; request to the converter core
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      conv_cfg       <= CFG_RESET;
      conv_request_o <= 1'b0;
      conv_count_o   <= 4'h0;
    end else begin
      conv_request_o <= 1'b0;
      if (state == CONV_IDLE && cnv_rise && !halt) begin
        conv_cfg       <= config_word;
        conv_request_o <= 1'b1;
        conv_count_o   <= chan_cnt_cfg;
      end
    end
  end

  // ==========================================================
  // two-entry buffer between converter core and result store
  logic [RES_W-1:0] buf_mem [2];
  logic             buf_wp;
  logic             buf_rp;
  logic [1:0]       buf_cnt;
  logic             buf_push;
  logic             buf_pop;
  logic             drain_ready;

  assign sample_ready_o = (buf_cnt != 2'h2);
  assign drain_ready    = (state == CONV_COLLECT) && (wr_ptr < chan_cnt);
  assign buf_push       = sample_valid_i & sample_ready_o;
  assign buf_pop        = (buf_cnt != 2'h0) & drain_ready;

  // buffer storage
  always_ff @(posedge clk_i) begin
    if (buf_push) begin
      buf_mem[buf_wp] <= sample_data_i;
    end
  end

  // buffer pointers, flushed on abort
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || halt) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_wp <= ~buf_wp;
      end
      if (buf_pop) begin
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ==========================================================
  // result banks: one filled, one read
  logic             bank;
  logic             results_valid;
  logic [RES_W-1:0] wr_data;
  logic [RES_W-1:0] rd_data_a;
  logic [RES_W-1:0] rd_data_b;
  logic [3:0]       rd_addr_a;
  logic [3:0]       rd_addr_b;
  logic [15:0]      read_cfg;
  logic [3:0]       read_cnt;
  logic             read_dual;

  // core delivers offset binary, flip msb for twos complement
  assign wr_data = {~buf_mem[buf_rp][RES_W-1], buf_mem[buf_rp][RES_W-2:0]};

  // write pointer restarts on every start
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state == CONV_IDLE) begin
      wr_ptr <= 4'h0;
    end else if (buf_pop) begin
      wr_ptr <= wr_ptr + 4'h1;
    end
  end

  // bank swap and readout settings at end of conversion
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || sync_b[SY_RST]) begin
      bank          <= 1'b0;
      results_valid <= 1'b0;
      read_cfg      <= CFG_RESET;
      read_cnt      <= 4'h8;
      read_dual     <= 1'b0;
    end else if (eoc) begin
      bank          <= ~bank;
      results_valid <= 1'b1;
      read_cfg      <= conv_cfg;
      read_cnt      <= chan_cnt;
      read_dual     <= ~conv_cfg[CFG_DUAL_BIT];
    end
  end

  // ==========================================================
  // configuration input and pipeline
  logic [15:0] cfg_shift;
  logic [15:0] cfg_pend;
  logic        pend_valid;
  logic [4:0]  in_cnt;

  // shift in on rising clock edges, msb first, first 16 only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || halt || eoc) begin
      in_cnt     <= 5'h00;
      pend_valid <= 1'b0;
    end else if (cs_fall) begin
      in_cnt <= 5'h00;
    end else if (!cs_s && sck_rise && in_cnt < 5'(CFG_BITS)) begin
      cfg_shift <= {cfg_shift[14:0], din_s};
      in_cnt    <= in_cnt + 5'h01;
      if (in_cnt == 5'(CFG_BITS - 1)) begin
        cfg_pend   <= {cfg_shift[14:0], din_s};
        pend_valid <= 1'b1;
      end
    end
  end

  // live settings; power-down keeps them, reset restores all ones
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || sync_b[SY_RST]) begin
      config_word <= CFG_RESET;
    end else if (eoc && pend_valid && cfg_pend[CFG_UPDATE_BIT]) begin
      config_word <= cfg_pend;
    end
  end

  assign config_word_o = config_word;

  // ==========================================================
  // serial readout
  logic [RES_W-1:0] sh_a;
  logic [RES_W-1:0] sh_b;
  logic [3:0]       bit_cnt;
  logic [3:0]       word_idx;
  logic [4:0]       nxt;
  logic [4:0]       lim;
  logic [RES_W-1:0] word_a;
  logic [RES_W-1:0] word_b;
  logic             busy_pin;
  logic             oe;

  // word to load next: index 0 while select is high
  assign nxt       = sync_c[SY_CS] ? 5'h00 : {1'b0, word_idx} + 5'h01;
  assign lim       = read_dual ? 5'(HALF_CHAN) : {1'b0, read_cnt};
  assign rd_addr_a = {bank, nxt[2:0]};
  assign rd_addr_b = {bank, nxt[2:0] + 3'(HALF_CHAN)};

  // choose result, config readback or zero
  always_comb begin
    word_a = '0;
    word_b = '0;
    if (results_valid) begin
      if (nxt < lim) begin
        word_a = rd_data_a;
        word_b = read_dual ? rd_data_b : '0;
      end else if (nxt == lim) begin
        word_a = read_cfg;
      end
    end
  end

  // load at select fall, shift on falling clock edges
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sh_a     <= '0;
      sh_b     <= '0;
      bit_cnt  <= 4'h0;
      word_idx <= 4'h0;
    end else if (cs_fall) begin
      sh_a     <= word_a;
      sh_b     <= word_b;
      bit_cnt  <= 4'h0;
      word_idx <= 4'h0;
    end else if (!cs_s && sck_fall) begin
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == 4'hf) begin
        sh_a <= word_a;
        sh_b <= word_b;
        if (word_idx != 4'hf) begin
          word_idx <= word_idx + 4'h1;
        end
      end else begin
        sh_a <= {sh_a[RES_W-2:0], 1'b0};
        sh_b <= {sh_b[RES_W-2:0], 1'b0};
      end
    end
  end

  // output enable and shared pin
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      oe       <= 1'b0;
      busy_pin <= 1'b0;
    end else begin
      oe <= ~cs_s & ~halt;
      if (cs_s || !read_dual) begin
        busy_pin <= busy;
      end else begin
        busy_pin <= sh_b[RES_W-1];
      end
    end
  end

  assign sdo_o                  = sh_a[RES_W-1];
  assign sdo_oe_o               = oe;
  assign busy_second_data_out_o = busy_pin;

  // ==========================================================
  // result memory
  result_store #(
    .ADDR_W (4),
    .DATA_W (RES_W)
  ) u_store (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .wr_en_i     (buf_pop),
    .wr_addr_i   ({~bank, wr_ptr[2:0]}),
    .wr_data_i   (wr_data),
    .rd_addr_a_i (rd_addr_a),
    .rd_addr_b_i (rd_addr_b),
    .rd_data_a_o (rd_data_a),
    .rd_data_b_o (rd_data_b)
  );

endmodule
`default_nettype wire

// ==== tb/simultaneous_adc_serial_control_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker for conversion and serial control
module simultaneous_adc_serial_control_monitor
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic             clk_i,
  input wire logic             sys_rst_i,
  input wire logic             device_reset_i,
  input wire logic             power_down_input_i,
  input wire logic             cs_n_i,
  input wire logic             conv_request_o,
  input wire logic [3:0]       conv_count_o,
  input wire logic             sdo_oe_o,
  input wire logic             busy_second_data_out_o,
  input wire logic [RES_W-1:0] config_word_o
);
  // one domain, checks off in reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // output enable against select, reset and power-down
  property p_oe_off;
    $rose(cs_n_i) |-> ##[1:6] !sdo_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output on after deselect");
  property p_oe_on;
    $fell(cs_n_i) ##1 (!cs_n_i && !device_reset_i && !power_down_input_i)[*6] |-> sdo_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output off while selected");
  property p_rst_off;
    $rose(device_reset_i) |-> ##[1:5] !sdo_oe_o;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("output on after reset pin");
  property p_pd_off;
    $rose(power_down_input_i) |-> ##[1:6] (!sdo_oe_o && (!busy_second_data_out_o || !cs_n_i));
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("no abort on power-down");
  // ==========================================================
  // start, busy, channel count, reset value
  property p_busy;
    conv_request_o && cs_n_i |=> (busy_second_data_out_o || !cs_n_i)[*2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised on start");
  property p_once;
    conv_request_o |=> !conv_request_o[*8];
  endproperty
  a_once: assert property (p_once) else $error("start taken while busy");
  property p_count;
    conv_request_o |-> conv_count_o == {1'b0, config_word_o[14:13], 1'b0} + 4'h2;
  endproperty
  a_count: assert property (p_count) else $error("wrong channel count");
  property p_cfg_rst;
    $fell(sys_rst_i) |-> config_word_o == CFG_RESET && !sdo_oe_o && !conv_request_o;
  endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("bad state after reset");
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// host serial controller
module host_model #(
  parameter int HALF_NS = 80
) (
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  input  wire logic busy2_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      din_o
);
  // deselected and idle from time zero
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    din_o  = 1'b0;
  end
  // one frame: config out msb first, each bit read before its advancing edge
  task automatic transfer(input logic idle, input logic [15:0] cfg, input int nbits,
                          output logic [159:0] rx, output logic [159:0] rx2);
    int i;
    rx    = '0;
    rx2   = '0;
    sck_o = idle;
    if (!idle) din_o = cfg[15]; // first bit settled before the first rising edge
    #(2 * HALF_NS);
    cs_n_o = 1'b0;
    #(2 * HALF_NS);
    // din moves only on falling edges, so it is settled at every rising edge
    for (i = 0; i < nbits; i++) begin
      rx    = {rx[158:0], sdo_oe_i ? sdo_i : ~rx[0]};
      rx2   = {rx2[158:0], busy2_i};
      if (idle) din_o = (i < 16) ? cfg[15 - i] : ~din_o;
      sck_o = ~idle;
      #(HALF_NS);
      sck_o = idle;
      if (!idle) din_o = (i < 15) ? cfg[14 - i] : ~din_o;
      #(HALF_NS);
    end
    cs_n_o = 1'b1;
    din_o  = ~din_o; // released line keeps no stale value
  endtask
endmodule
`default_nettype wire

// ==== tb/test_simultaneous_adc_serial_control.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// self-checking bench
module test_simultaneous_adc_serial_control
  import adc_ctrl_pkg::*;
  ;
  localparam int CC  = 4;  // short conversion keeps the run brief
  localparam int ACQ = 20; // acquisition wait after device reset, arbitrary
  logic         clk_i = 1'b0, sys_rst_i = 1'b1, sample_valid_i = 1'b0;
  logic         conversion_start_i = 1'b0, device_reset_i = 1'b0, power_down_input_i = 1'b0;
  logic [15:0]  sample_data_i = 16'h0000;
  logic         cs_n_i, sck_i, din_i, conv_request_o, sample_ready_o, sdo_o, sdo_oe_o;
  logic         busy_second_data_out_o;
  logic [3:0]   conv_count_o;
  logic [15:0]  config_word_o;
  logic [159:0] rx, rx2;
  int           bad_count = 0, comparisons = 0, cycles = 0, requests = 0;
  // ==========================================================
  // design, host, clock
  simultaneous_adc_serial_control #(.CONV_CYCLES(CC)) DUT (.*);
  host_model host (.sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .busy2_i(busy_second_data_out_o),
                   .cs_n_o(cs_n_i), .sck_o(sck_i), .din_o(din_i));
  always #10 clk_i = ~clk_i;
  // counts starts; ceiling about seven times the expected run
  always @(negedge clk_i) begin
    cycles++;
    if (conv_request_o === 1'b1) requests++;
    if (cycles == 50000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // result words then config readback
  task automatic words(input logic [159:0] v, input int nbits, input int nw,
                       input logic [15:0] base, input logic [15:0] cfg);
    int k;
    logic [159:0] s;
    for (k = 0; k <= nw; k++) begin
      s = v >> (nbits - 16 * (k + 1));
      check(s[15:0], (k < nw) ? (base + 16'(k)) ^ 16'h8000 : cfg);
    end
  endtask
  // one conversion with a retrigger while busy, samples fed through the buffer
  task automatic convert(input logic [15:0] base, input logic [3:0] n);
    int i;
    int r0;
    r0 = requests;
    @(negedge clk_i);
    conversion_start_i = 1'b1;
    for (i = 0; i < 20 && conv_request_o !== 1'b1; i++) @(negedge clk_i);
    check({12'h000, conv_count_o}, {12'h000, n});
    conversion_start_i = 1'b0;
    repeat (2) @(negedge clk_i);
    conversion_start_i = 1'b1;
    for (i = 0; i < n; i++) begin
      sample_valid_i = 1'b1;
      sample_data_i  = base + 16'(i);
      if (i == 2) check({15'h0000, sample_ready_o}, 16'h0000);
      while (sample_ready_o !== 1'b1) @(negedge clk_i);
      @(negedge clk_i);
    end
    sample_valid_i = 1'b0;
    for (i = 0; i < 200 && busy_second_data_out_o !== 1'b0; i++) @(negedge clk_i);
    check({15'h0000, busy_second_data_out_o}, 16'h0000);
    check(16'(requests - r0), 16'h0001);
    conversion_start_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_pipeline();
    check(config_word_o, CFG_RESET);
    convert(16'h0100, 4'h8);
    host.transfer(1'b0, 16'hfffe, 144, rx, rx2);
    words(rx, 144, 8, 16'h0100, CFG_RESET);
    check(config_word_o, CFG_RESET);
    convert(16'h0200, 4'h8);
    check(config_word_o, 16'hfffe);
    host.transfer(1'b1, 16'h3fff, 144, rx, rx2);
    words(rx, 144, 8, 16'h0200, CFG_RESET);
    convert(16'h0300, 4'h8);
    check(config_word_o, 16'hfffe);
    host.transfer(1'b0, 16'hbfff, 8, rx, rx2);
    convert(16'h0400, 4'h8);
    check(config_word_o, 16'hfffe);
    host.transfer(1'b0, 16'hbfff, 80, rx, rx2);
    words(rx, 80, 4, 16'h0400, 16'hfffe);
    words(rx2, 80, 4, 16'h0404, 16'h0000);
    convert(16'h0500, 4'h8);
    check(config_word_o, 16'hbfff);
    convert(16'h0600, 4'h4);
    host.transfer(1'b0, 16'h7fff, 80, rx, rx2);
    words(rx, 80, 4, 16'h0600, 16'hbfff);
    // six and then two channels through the pipeline
    host.transfer(1'b0, 16'hdfff, 16, rx, rx2);
    convert(16'h0800, 4'h4);
    check(config_word_o, 16'hdfff);
    convert(16'h0900, 4'h6);
    host.transfer(1'b0, 16'h9fff, 112, rx, rx2);
    words(rx, 112, 6, 16'h0900, 16'hdfff);
    convert(16'h0a00, 4'h6);
    convert(16'h0b00, 4'h2);
    host.transfer(1'b0, 16'h7fff, 48, rx, rx2);
    words(rx, 48, 2, 16'h0b00, 16'h9fff);
  endtask
  // device reset mid frame, read before a start, power-down mid conversion
  task automatic s_abort();
    fork
      host.transfer(1'b0, 16'h7fff, 144, rx, rx2);
      begin
        repeat (100) @(negedge clk_i);
        device_reset_i = 1'b1;
        repeat (4) @(negedge clk_i);
        device_reset_i = 1'b0;
      end
    join
    check(config_word_o, CFG_RESET);
    host.transfer(1'b0, 16'h7fff, 16, rx, rx2);
    words(rx, 16, 0, 16'h0000, 16'h0000);
    repeat (ACQ) @(negedge clk_i);
    conversion_start_i = 1'b1;
    repeat (6) @(negedge clk_i);
    check({15'h0000, busy_second_data_out_o}, 16'h0001);
    power_down_input_i = 1'b1;
    repeat (8) @(negedge clk_i);
    check({15'h0000, busy_second_data_out_o}, 16'h0000);
    power_down_input_i = 1'b0;
    conversion_start_i = 1'b0;
    repeat (10) @(negedge clk_i);
    convert(16'h0700, 4'h8);
  endtask
  // ==========================================================
  // verdict and main sequence
  task automatic give_verdict();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    s_pipeline();
    s_abort();
    give_verdict();
  end
endmodule
bind simultaneous_adc_serial_control simultaneous_adc_serial_control_monitor
  #(.CONV_CYCLES(CONV_CYCLES)) mon (.*);
`default_nettype wire
